// file: rtl/hip_defs.svh
// Constants of the host indirect register port: direct offsets, global
// indirect addresses, field positions, reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef HIP_DEFS_SVH
`define HIP_DEFS_SVH

// ================================================================
// Direct locations on the three-bit address
`define HIP_DIR_DATA_LO      3'h0
`define HIP_DIR_DATA_HI      3'h1
`define HIP_DIR_LAUNCH       3'h2
`define HIP_DIR_STATUS       3'h2
`define HIP_DIR_RDSEL        3'h3
`define HIP_DIR_SEQ_BASE     3'h4

// ================================================================
// Global indirect addresses (low byte, upper byte zero)
`define HIP_GA_TOP_CTRL      8'h00
`define HIP_GA_EOUT_MAP      8'h01
`define HIP_GA_TEST_CTRL     8'h02
`define HIP_GA_TEST_LOAD     8'h03
`define HIP_GA_SYNC_GEN      8'h04
`define HIP_GA_SYNC_FB       8'h05
`define HIP_GA_SOFT_RESET    8'h06

// ================================================================
// Indirect address fields
`define HIP_CHAN_SEL_HI      15
`define HIP_CHAN_SEL_LO      12
`define HIP_IO_SEL_HI        11
`define HIP_IO_SEL_LO        8

// ================================================================
// Reset and fixed read values
`define HIP_RST_WORD         32'h0000_0000
`define HIP_RST_ADDR         16'h0000
`define HIP_RD_RESERVED      16'h0000
`define HIP_RD_NONE          32'h0000_0000

// ================================================================
// Write strobe synchronisation, in clock cycles
`define HIP_SYNC_CYCLES      4

`endif

// file: rtl/hip_pkg.sv
// Types shared by the host indirect register port.
// Assumes nothing beyond a SystemVerilog compiler.
package hip_pkg;

  // ================================================================
  // Write strobe synchroniser states, one-hot
  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b01,
    SYNC_WAIT = 2'b10
  } sync_state_type;

endpackage

// file: rtl/write_strobe_sync.sv
// Synchroniser that turns a launch pulse into an internal write strobe
// a fixed number of clock cycles later.
// Assumes launch_i is a one-cycle pulse in the clk_i domain.
`include "hip_defs.svh"

module write_strobe_sync
  import hip_pkg::*;
#(
  parameter int SYNC_CYCLES = `HIP_SYNC_CYCLES
) (
  input  wire logic clk_i,     // System clock
  input  wire logic rst_i,     // Synchronous reset, active high
  input  wire logic launch_i,  // Launch pulse from the address write
  output logic      busy_o,    // Synchronisation in progress
  output logic      strobe_o   // One-cycle internal write strobe
);

  localparam logic [3:0] CNT_LOAD = 4'(SYNC_CYCLES - 1);

  sync_state_type state_q;
  sync_state_type state_d;
  logic [3:0]     cnt_q;
  logic [3:0]     cnt_d;
  wire logic      done;

  // ================================================================
  // Strobe fires in the last counted cycle
  assign done     = (state_q == SYNC_WAIT) && (cnt_q == 4'h0);
  assign strobe_o = done;
  assign busy_o   = (state_q == SYNC_WAIT);

  // Next state; a launch during a wait is ignored, the host must space them
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      SYNC_IDLE: begin
        if (launch_i) begin
          state_d = SYNC_WAIT;
          cnt_d   = CNT_LOAD;
        end
      end
      SYNC_WAIT: begin
        if (done) begin
          state_d = SYNC_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        state_d = SYNC_IDLE;
        cnt_d   = 4'h0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SYNC_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

endmodule

// file: rtl/global_register_bank.sv
// Global indirect registers: three stored controls and four one-shot strobes.
// Assumes wr_stb_i is a one-cycle pulse already qualified as a global write.
`include "hip_defs.svh"

module global_register_bank (
  input  wire logic        clk_i,          // System clock
  input  wire logic        rst_i,          // Synchronous reset, active high
  input  wire logic        wr_stb_i,       // Global write strobe
  input  wire logic [7:0]  wr_addr_i,      // Global write address
  input  wire logic [31:0] wr_data_i,      // Global write data
  input  wire logic [7:0]  rd_addr_i,      // Global read address
  output logic      [31:0] rd_data_o,      // Global read data
  output logic      [31:0] top_ctrl_o,     // Output controls and routing
  output logic      [31:0] eout_map_o,     // Range control to expansion pins
  output logic      [31:0] test_ctrl_o,    // Test data and test enables
  output logic             test_load_o,    // Test data load pulse
  output logic             strobe_pulse_output_o, // Sync output pulse
  output logic             first_sync_input_o,    // Internal sync input 1 pulse
  output logic             soft_reset_o    // Software hard reset pulse
);

  logic [31:0] top_q;
  logic [31:0] eout_q;
  logic [31:0] test_q;
  logic [3:0]  shot_q;
  wire logic   wr_top;
  wire logic   wr_eout;
  wire logic   wr_test;
  wire logic [3:0] wr_shot;

  // ================================================================
  // Write decode; reserved addresses match nothing and change nothing
  assign wr_top     = wr_stb_i && (wr_addr_i == `HIP_GA_TOP_CTRL);   // R08 R12
  assign wr_eout    = wr_stb_i && (wr_addr_i == `HIP_GA_EOUT_MAP);   // R09
  assign wr_test    = wr_stb_i && (wr_addr_i == `HIP_GA_TEST_CTRL);  // R10
  assign wr_shot[0] = wr_stb_i && (wr_addr_i == `HIP_GA_TEST_LOAD);  // R11
  assign wr_shot[1] = wr_stb_i && (wr_addr_i == `HIP_GA_SYNC_GEN);   // R11
  assign wr_shot[2] = wr_stb_i && (wr_addr_i == `HIP_GA_SYNC_FB);    // R11
  assign wr_shot[3] = wr_stb_i && (wr_addr_i == `HIP_GA_SOFT_RESET); // R11

  // Stored controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      top_q  <= `HIP_RST_WORD;
      eout_q <= `HIP_RST_WORD;
      test_q <= `HIP_RST_WORD;
    end else begin
      if (wr_top)  top_q  <= wr_data_i;
      if (wr_eout) eout_q <= wr_data_i;
      if (wr_test) test_q <= wr_data_i;
    end
  end

  // One-shots hold nothing: a registered pulse per write
  always_ff @(posedge clk_i) begin
    if (rst_i) shot_q <= 4'h0;
    else       shot_q <= wr_shot; // R11
  end

  assign top_ctrl_o            = top_q;
  assign eout_map_o            = eout_q;
  assign test_ctrl_o           = test_q;
  assign test_load_o           = shot_q[0];
  assign strobe_pulse_output_o = shot_q[1] | shot_q[2];
  assign first_sync_input_o    = shot_q[2];
  assign soft_reset_o          = shot_q[3];

  // ================================================================
  // Readback: stored words only, strobe and reserved locations read zero
  assign rd_data_o = (rd_addr_i == `HIP_GA_TOP_CTRL)  ? top_q  :   // R17
                     (rd_addr_i == `HIP_GA_EOUT_MAP)  ? eout_q :
                     (rd_addr_i == `HIP_GA_TEST_CTRL) ? test_q : `HIP_RD_NONE;

endmodule

// file: rtl/host_indirect_register_port.sv
// Microprocessor register port of a four-channel downconverter: eight direct
// 16-bit locations giving indirect access to a 32-bit internal register space.
// Assumes all host pins are synchronous to clk_i and the data bus is
// resolved outside from p_o and p_oe_n_o.
//
// How it works
// R01 - Direct 0 write loads holding low half
// R02 - Direct 1 write loads holding high half
// R03 - Direct 2 stores address, strobes holding word
// R04 - Direct 3 sets shared address, no strobe
// R05 - Direct 0/1 reads return selected register
// R06 - Direct 4-7 reads give channel sequenced data
// R07 - Address nibble selects channel or I/O set
// R08 - Global 0000h holds output controls, routing
// R09 - Global 0001h maps range control outputs
// R10 - Global 0002h holds test data, enables
// R11 - Global 0003h-0006h are one-shot strobes
// R12 - Global 0007h-00FFh writes change nothing
// R13 - Host waits four clocks after direct 2
// R14 - Bits 15:12 select channels, write broadcast
// R15 - Bits 11:8 select I/O sections, broadcast
// R16 - Status low byte: saturation, zero pairs
// R17 - Global reads return stored controls only
// R18 - Reserved direct writes ignored, 3 reads fixed
`include "hip_defs.svh"

module host_indirect_register_port
  import hip_pkg::*;
#(
  parameter int         NUM_CHAN    = 4,
  parameter int         SYNC_CYCLES = `HIP_SYNC_CYCLES,
  parameter logic [7:0] REVISION    = 8'h5a  // Arbitrary revision code
) (
  input  wire logic                     clk_i,        // System clock, 10 MHz
  input  wire logic                     rst_i,        // Synchronous reset, active high
  // Host parallel port
  input  wire logic                     ce_n_i,       // Chip enable, active low
  input  wire logic                     wr_n_i,       // Write strobe, active low
  input  wire logic                     rd_n_i,       // Read strobe, active low
  input  wire logic [2:0]               add_i,        // Direct address
  input  wire logic [15:0]              p_i,          // Data bus in
  output logic      [15:0]              p_o,          // Data bus out
  output logic                          p_oe_n_o,     // Data bus enable, low drives
  // Channel and I/O register sets
  output logic                          ind_wr_stb_o, // Non-global write pulse
  output logic      [15:0]              ind_wr_addr_o,// Target indirect address
  output logic      [31:0]              ind_wr_data_o,// Target write data
  output logic      [NUM_CHAN-1:0]      chan_wr_sel_o,// Channel write selects
  output logic      [3:0]               io_wr_sel_o,  // I/O section write selects
  output logic      [15:0]              ind_rd_addr_o,// Readback address
  output logic      [NUM_CHAN-1:0]      chan_rd_sel_o,// One-hot channel read select
  output logic      [3:0]               io_rd_sel_o,  // One-hot I/O read select
  input  wire logic [31:0]              ext_rd_data_i,// Selected set's read data
  input  wire logic [NUM_CHAN*16-1:0]   seq_data_i,   // Sequenced read data
  output logic      [NUM_CHAN-1:0]      seq_rd_done_o,// Sequenced read completed
  input  wire logic [NUM_CHAN-1:0]      sat_i,        // Data path saturation
  output logic                          wr_busy_o,    // Strobe sync running
  // Global controls
  output logic      [31:0]              top_ctrl_o,   // Output controls, routing
  output logic      [31:0]              eout_map_o,   // Expansion pin mapping
  output logic      [31:0]              test_ctrl_o,  // Test data and enables
  output logic                          test_load_o,  // Test data load pulse
  output logic                          strobe_pulse_output_o, // Sync out pulse
  output logic                          first_sync_input_o,    // Sync in 1 feedback
  output logic                          soft_reset_o  // Software hard reset pulse
);

  // ================================================================
  // Host strobe qualification
  wire logic        wr_act;
  wire logic        rd_act;
  wire logic        wr_take;
  wire logic        rd_end;
  logic             wr_prev_q;
  logic             rd_prev_q;
  logic [2:0]       rd_addr_q;

  // Chip enable gates both strobes
  assign wr_act  = !ce_n_i && !wr_n_i;
  assign rd_act  = !ce_n_i && !rd_n_i;
  // A write is taken once, in the first cycle of its strobe
  assign wr_take = wr_act && !wr_prev_q;
  // A read ends when its strobe is released
  assign rd_end  = !rd_act && rd_prev_q;

  // Strobe history and address of the read in progress
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      rd_addr_q <= 3'h0;
    end else begin
      wr_prev_q <= wr_act;
      rd_prev_q <= rd_act;
      if (rd_act) rd_addr_q <= add_i;
    end
  end

  // ================================================================
  // Direct write decode; locations 4 to 7 have no write target
  wire logic wr_lo;
  wire logic wr_hi;
  wire logic wr_launch;
  wire logic wr_rdsel;

  assign wr_lo     = wr_take && (add_i == `HIP_DIR_DATA_LO); // R01
  assign wr_hi     = wr_take && (add_i == `HIP_DIR_DATA_HI); // R02
  assign wr_launch = wr_take && (add_i == `HIP_DIR_LAUNCH);  // R03
  assign wr_rdsel  = wr_take && (add_i == `HIP_DIR_RDSEL);   // R04 R18

  // ================================================================
  // Holding word and shared indirect address
  logic [15:0] hold_lo_q;
  logic [15:0] hold_hi_q;
  logic [15:0] ind_addr_q;

  // Holding halves only store; nothing internal changes until a launch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_lo_q  <= 16'(`HIP_RST_WORD >> 16);
      hold_hi_q  <= 16'(`HIP_RST_WORD >> 16);
      ind_addr_q <= `HIP_RST_ADDR;
    end else begin
      if (wr_lo)              hold_lo_q  <= p_i;  // R01
      if (wr_hi)              hold_hi_q  <= p_i;  // R02
      if (wr_launch || wr_rdsel) ind_addr_q <= p_i; // R03 R04
    end
  end

  // ================================================================
  // Launch capture: the word and address are frozen at the launch so a
  // read-select write during synchronisation cannot redirect the strobe
  logic [31:0] tgt_data_q;
  logic [15:0] tgt_addr_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgt_data_q <= `HIP_RST_WORD;
      tgt_addr_q <= `HIP_RST_ADDR;
    end else if (wr_launch && !wr_busy_o) begin
      tgt_data_q <= {hold_hi_q, hold_lo_q}; // R03
      tgt_addr_q <= p_i;
    end
  end

  // ================================================================
  // Write strobe synchroniser; the host keeps clear of 0 and 1 meanwhile
  wire logic sync_stb;

  write_strobe_sync #(
    .SYNC_CYCLES (SYNC_CYCLES)
  ) u_sync (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .launch_i (wr_launch),
    .busy_o   (wr_busy_o),   // R13
    .strobe_o (sync_stb)
  );

  // ================================================================
  // Target decode: global space is the upper byte all zero
  wire logic       tgt_global;
  wire logic       glb_wr_stb;
  wire logic       ext_wr_stb;
  wire logic [3:0] tgt_chan;
  wire logic [3:0] tgt_io;

  assign tgt_global = (tgt_addr_q[15:8] == 8'h00);
  assign glb_wr_stb = sync_stb && tgt_global;  // R03
  assign ext_wr_stb = sync_stb && !tgt_global; // R03
  // Channel bits win; I/O bits count only with no channel bit set
  assign tgt_chan   = tgt_addr_q[`HIP_CHAN_SEL_HI:`HIP_CHAN_SEL_LO]; // R07 R14
  assign tgt_io     = (tgt_chan == 4'h0) ?
                      tgt_addr_q[`HIP_IO_SEL_HI:`HIP_IO_SEL_LO] : 4'h0; // R15

  // Registered strobe towards the channel and I/O sets
  logic ext_stb_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) ext_stb_q <= 1'b0;
    else       ext_stb_q <= ext_wr_stb;
  end

  // Several select bits set broadcast the one write
  assign ind_wr_stb_o  = ext_stb_q;
  assign ind_wr_addr_o = tgt_addr_q;
  assign ind_wr_data_o = tgt_data_q;
  assign chan_wr_sel_o = tgt_chan[NUM_CHAN-1:0]; // R14
  assign io_wr_sel_o   = tgt_io;                 // R15

  // ================================================================
  // Global registers and one-shot strobes
  wire logic [31:0] glb_rd_data;

  global_register_bank u_glb (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .wr_stb_i              (glb_wr_stb),
    .wr_addr_i             (tgt_addr_q[7:0]),
    .wr_data_i             (tgt_data_q),
    .rd_addr_i             (ind_addr_q[7:0]),
    .rd_data_o             (glb_rd_data),
    .top_ctrl_o            (top_ctrl_o),
    .eout_map_o            (eout_map_o),
    .test_ctrl_o           (test_ctrl_o),
    .test_load_o           (test_load_o),
    .strobe_pulse_output_o (strobe_pulse_output_o),
    .first_sync_input_o    (first_sync_input_o),
    .soft_reset_o          (soft_reset_o)
  );

  // ================================================================
  // Readback select: reads must name exactly one channel or one section
  wire logic [3:0] rd_chan;
  wire logic [3:0] rd_io;
  wire logic       rd_global;
  wire logic       chan_one;
  wire logic       io_one;
  wire logic [31:0] ind_rd_word;

  assign rd_chan   = ind_addr_q[`HIP_CHAN_SEL_HI:`HIP_CHAN_SEL_LO];
  assign rd_io     = ind_addr_q[`HIP_IO_SEL_HI:`HIP_IO_SEL_LO];
  assign rd_global = (ind_addr_q[15:8] == 8'h00);
  assign chan_one  = $onehot(rd_chan);                      // R14
  assign io_one    = (rd_chan == 4'h0) && $onehot(rd_io);   // R15

  assign ind_rd_addr_o = ind_addr_q;
  assign chan_rd_sel_o = chan_one ? rd_chan[NUM_CHAN-1:0] : '0; // R07
  assign io_rd_sel_o   = io_one ? rd_io : 4'h0;                 // R07

  // An ambiguous selection reads as zero rather than a mix of sets
  assign ind_rd_word = rd_global           ? glb_rd_data   :   // R17
                       (chan_one || io_one) ? ext_rd_data_i : `HIP_RD_NONE;

  // ================================================================
  // Status word: per channel a saturation bit under an always-zero bit
  logic [15:0] status_word;

  always_comb begin
    status_word = {REVISION, 8'h00};
    for (int c = 0; c < NUM_CHAN; c++) begin
      status_word[2*c]   = sat_i[c]; // R16
      status_word[2*c+1] = 1'b0;     // R16
    end
  end

  // Sequenced read word of the channel at the current address
  wire logic [15:0] seq_word;
  wire logic [1:0]  seq_idx;

  assign seq_idx  = add_i[1:0];
  assign seq_word = seq_data_i[16*seq_idx +: 16]; // R06

  // ================================================================
  // Direct read multiplexer
  logic [15:0] rd_mux;

  always_comb begin
    case (add_i)
      `HIP_DIR_DATA_LO: rd_mux = ind_rd_word[15:0];  // R05
      `HIP_DIR_DATA_HI: rd_mux = ind_rd_word[31:16]; // R05
      `HIP_DIR_STATUS:  rd_mux = status_word;        // R16
      `HIP_DIR_RDSEL:   rd_mux = `HIP_RD_RESERVED;   // R18
      default:          rd_mux = seq_word;           // R06
    endcase
  end

  // Read data is registered while the read strobe is held
  logic [15:0] p_q;

  always_ff @(posedge clk_i) begin
    if (rst_i)       p_q <= 16'h0000;
    else if (rd_act) p_q <= rd_mux;
  end

  assign p_o      = p_q;
  assign p_oe_n_o = !rd_act;

  // ================================================================
  // Sequenced read completion steps that channel's read pointer
  logic [NUM_CHAN-1:0] seq_done_q;

  generate
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_seq
      always_ff @(posedge clk_i) begin
        if (rst_i) seq_done_q[c] <= 1'b0;
        else       seq_done_q[c] <= rd_end && (rd_addr_q == 3'(`HIP_DIR_SEQ_BASE + c)); // R06
      end
    end
  endgenerate

  assign seq_rd_done_o = seq_done_q;

endmodule

// file: test/hip_props.sv
// Assertions on the ports of the host register port.
// Assumes the bind hands on the parameters.
module hip_props #(
  parameter int         NUM_CHAN = 4,
  parameter logic [7:0] REVISION = 8'h5a
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  ce_n_i,
  input wire logic                  wr_n_i,
  input wire logic                  rd_n_i,
  input wire logic [2:0]            add_i,
  input wire logic [15:0]           p_i,
  input wire logic [15:0]           p_o,
  input wire logic                  p_oe_n_o,
  input wire logic                  ind_wr_stb_o,
  input wire logic [15:0]           ind_wr_addr_o,
  input wire logic [NUM_CHAN-1:0]   chan_wr_sel_o,
  input wire logic [15:0]           ind_rd_addr_o,
  input wire logic [NUM_CHAN-1:0]   chan_rd_sel_o,
  input wire logic [NUM_CHAN*16-1:0] seq_data_i,
  input wire logic [NUM_CHAN-1:0]   sat_i,
  input wire logic                  wr_busy_o,
  input wire logic                  test_load_o,
  input wire logic                  strobe_pulse_output_o,
  input wire logic                  first_sync_input_o,
  input wire logic                  soft_reset_o,
  input wire logic [31:0]           top_ctrl_o
);
  // ========
  // Write taken on the first low strobe cycle only
  logic        wr_prev_q;
  logic        take;
  logic        launch;
  logic        rd;
  logic [3:0]  sat_q;
  logic [15:0] seq_q;
  assign take   = !ce_n_i && !wr_n_i && !wr_prev_q;
  assign launch = take && add_i == 3'h2 && !wr_busy_o;
  assign rd     = !ce_n_i && !rd_n_i;
  always_ff @(posedge clk_i) begin
    wr_prev_q <= !rst_i && !ce_n_i && !wr_n_i;
    sat_q     <= sat_i[3:0];
    seq_q     <= seq_data_i[16*add_i[1:0] +: 16];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ========
  // Port rules
  launch_busy_a: assert property (
    launch |=> wr_busy_o [*4] ##1 !wr_busy_o) else $error("busy span");
  chan_strobe_a: assert property (
    launch && p_i[15:8] != 8'h00 |-> ##5 ind_wr_stb_o && ind_wr_addr_o == $past(p_i, 5))
    else $error("target strobe");
  sync_gen_a: assert property (
    launch && p_i == 16'h0004 |-> ##5 strobe_pulse_output_o && !first_sync_input_o)
    else $error("sync out");
  sync_fb_a: assert property (
    launch && p_i == 16'h0005 |-> ##5 strobe_pulse_output_o && first_sync_input_o)
    else $error("sync feedback");
  reserved_glob_a: assert property (
    launch && p_i inside {[16'h0007:16'h00ff]} |-> ##5 !test_load_o && !soft_reset_o
    && !strobe_pulse_output_o && !ind_wr_stb_o && $stable(top_ctrl_o))
    else $error("reserved acted");
  rdsel_addr_a: assert property (
    take && add_i == 3'h3 && !wr_busy_o |=> ind_rd_addr_o == $past(p_i))
    else $error("read select not stored");
  no_strobe_a: assert property (
    take && add_i == 3'h3 && !wr_busy_o |=> !wr_busy_o [*2]) else $error("read select strobed");
  res_direct_a: assert property (
    take && add_i[2] |=> $stable(ind_rd_addr_o) && !wr_busy_o) else $error("direct 4-7 acted");
  oe_read_a: assert property (
    p_oe_n_o == !rd) else $error("bus enable wrong");
  status_a: assert property (
    rd && add_i == 3'h2 |=> p_o == {REVISION, 1'b0, sat_q[3], 1'b0, sat_q[2],
    1'b0, sat_q[1], 1'b0, sat_q[0]}) else $error("status word wrong");
  seq_read_a: assert property (
    rd && add_i[2] |=> p_o == seq_q) else $error("sequenced read wrong");
  chan_rdsel_a: assert property (
    chan_rd_sel_o == ($onehot(ind_rd_addr_o[15:12]) ? ind_rd_addr_o[15:12] : 4'h0))
    else $error("chan rd sel");
  chan_wrsel_a: assert property (
    ind_wr_stb_o |-> chan_wr_sel_o == ind_wr_addr_o[15:12]) else $error("channel write select");
endmodule

bind host_indirect_register_port hip_props #(.NUM_CHAN(NUM_CHAN), .REVISION(REVISION)) chk (.*);

// file: test/host_model.sv
// Host processor model on the 16-bit register port.
// Assumes the bench resolves the bus.
module host_model (
  input  wire logic        clk_i,  // System clock
  input  wire logic [15:0] bus_i,  // Resolved data bus
  output logic             ce_n_o, // Chip enable, active low
  output logic             wr_n_o, // Write strobe, active low
  output logic             rd_n_o, // Read strobe, active low
  output logic [2:0]       add_o,  // Direct address
  output logic [15:0]      dat_o   // Write data, inverted once released
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ce_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    add_o  = 3'h0;
    dat_o  = 16'h0000;
  end
  // ========
  // A slow host holds the strobe; only its first cycle counts
  task automatic wr(input logic [2:0] a, input logic [15:0] d, input int hold);
    ce_n_o = 1'b0;
    wr_n_o = 1'b0;
    add_o  = a;
    dat_o  = d;
    repeat (hold) @(posedge clk_i);
    #1;
    ce_n_o = 1'b1;
    wr_n_o = 1'b1;
    dat_o  = ~d;
    repeat (a == 3'h2 ? 5 : 1) @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    ce_n_o = 1'b0;
    rd_n_o = 1'b0;
    add_o  = a;
    @(posedge clk_i);
    #1;
    d      = bus_i;
    ce_n_o = 1'b1;
    rd_n_o = 1'b1;
    @(posedge clk_i);
    #1;
  endtask
endmodule

// file: test/tb.sv
// Self-checking bench of the host register port.
// Assumes design, checker and host model are compiled.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] REV = 8'h5a; // Arbitrary revision code
  logic        clk_i, rst_i, ce_n, wr_n, rd_n, p_oe_n_o, ind_wr_stb_o;
  logic        test_load_o, spo, fsi, soft_reset_o;
  logic [2:0]  add;
  logic [15:0] dat, p_o, bus, rdat, ind_wr_addr_o, ind_rd_addr_o;
  logic [31:0] ind_wr_data_o, top_ctrl_o, eout_map_o, test_ctrl_o, ext_rd, w;
  logic [3:0]  chan_wr_sel_o, io_wr_sel_o, chan_rd_sel_o, io_rd_sel_o, sat, done;
  logic [63:0] seq;
  int          fail_count, comparisons, n_stb, n_load, n_spo, n_fsi, n_rst;
  // ========
  // Design owns the bus while its enable is low
  assign bus = p_oe_n_o ? dat : p_o;
  host_model host (.clk_i, .bus_i(bus), .ce_n_o(ce_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
    .add_o(add), .dat_o(dat));
  host_indirect_register_port #(.REVISION(REV)) uut (
    .clk_i, .rst_i, .ce_n_i(ce_n), .wr_n_i(wr_n), .rd_n_i(rd_n), .add_i(add), .p_i(bus),
    .p_o, .p_oe_n_o, .ind_wr_stb_o, .ind_wr_addr_o, .ind_wr_data_o, .chan_wr_sel_o,
    .io_wr_sel_o, .ind_rd_addr_o, .chan_rd_sel_o, .io_rd_sel_o, .ext_rd_data_i(ext_rd),
    .seq_data_i(seq), .seq_rd_done_o(done), .sat_i(sat), .wr_busy_o(), .top_ctrl_o,
    .eout_map_o, .test_ctrl_o, .test_load_o, .strobe_pulse_output_o(spo),
    .first_sync_input_o(fsi), .soft_reset_o);
  // ========
  // Pulses are counted since the host tasks block across them
  always @(posedge clk_i) begin
    if (ind_wr_stb_o === 1'b1) n_stb++;
    if (test_load_o === 1'b1) n_load++;
    if (spo === 1'b1) n_spo++;
    if (fsi === 1'b1) n_fsi++;
    if (soft_reset_o === 1'b1) n_rst++;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rdword(input logic [15:0] a, output logic [31:0] v);
    logic [15:0] lo, hi;
    host.wr(3'h3, a, 1);
    host.rd(3'h0, lo);
    host.rd(3'h1, hi);
    v = {hi, lo};
  endtask
  // ========
  // Stored globals; high half reused from the first load
  task automatic t_global;
    for (int i = 0; i < 3; i++) begin
      w = {16'hc3a5, 16'h4560 + 16'(i)};
      if (i == 0) host.wr(3'h1, w[31:16], 2);
      host.wr(3'h0, w[15:0], i + 1);
      host.wr(3'h2, 16'(i), 1);
      check(i == 0 ? top_ctrl_o : i == 1 ? eout_map_o : test_ctrl_o, w);
      rdword(16'(i), w);
      check(w, {16'hc3a5, 16'h4560 + 16'(i)});
    end
  endtask
  // One-shot globals, then reserved ones
  task automatic t_strobes;
    for (int a = 3; a < 9; a++)
      host.wr(3'h2, a < 7 ? 16'(a) : 16'h00ff - 16'(8 - a) * 16'h00f8, 1);
    check({5'(n_load), 5'(n_spo), 5'(n_fsi), 5'(n_rst), 12'(n_stb)},
      {5'd1, 5'd2, 5'd1, 5'd1, 12'd0});
    check(top_ctrl_o, 32'hc3a5_4560);
    rdword(16'h0004, w);
    check(w, 32'h0);
  endtask
  // Channel and section selects
  task automatic t_chan;
    host.wr(3'h0, 16'h0042, 1);
    host.wr(3'h1, 16'hfeed, 1);
    host.wr(3'h2, 16'h3011, 1);
    check({ind_wr_addr_o, chan_wr_sel_o, 12'(n_stb)}, {16'h3011, 4'h3, 12'd1});
    check(ind_wr_data_o, 32'hfeed_0042);
    host.wr(3'h2, 16'h0502, 1);
    check({io_wr_sel_o, chan_wr_sel_o}, 8'h50);
    rdword(16'h2000, w);
    check(w, ext_rd);
    check(chan_rd_sel_o, 4'h2);
    host.wr(3'h3, 16'h0800, 1);
    check({io_rd_sel_o, chan_rd_sel_o}, 8'h80);
    host.wr(3'h3, 16'h3000, 1);
    check(chan_rd_sel_o, 4'h0);
  endtask
  // Status, reserved and sequenced direct locations
  task automatic t_direct;
    host.rd(3'h2, rdat);
    check(rdat, {REV, 8'h44});
    host.rd(3'h3, rdat);
    check(rdat, 16'h0);
    for (int c = 0; c < 4; c++) begin
      host.rd(3'(4 + c), rdat);
      check({rdat, done}, {seq[16*c +: 16], 4'(1 << c)});
      host.wr(3'(4 + c), 16'hbeef, 1);
      check({ind_rd_addr_o, 12'(n_stb)}, {16'h3000, 12'd2});
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    print_verdict;
  end
  initial begin
    rst_i  = 1'b1;
    ext_rd = 32'h89ab_cdef;
    seq    = 64'h4d44_3c33_2b22_1a11;
    sat    = 4'b1010;
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_global;
    t_strobes;
    t_chan;
    t_direct;
    print_verdict;
  end
endmodule
